// File: hdl/hbtu_pkg.sv
// Purpose: Constants and types for the hardware breakpoint trigger unit
// Assumes: 32-bit addresses, one hart, eight slots
// Notes:   Field positions follow the match control word layout
package hbtu_pkg;
   localparam int          SLOTS        = 8;
   localparam int          IDX_W        = 3;
   // CSR selector codes on the csr port
   localparam logic [1:0]  CSR_INDEX    = 2'h0;
   localparam logic [1:0]  CSR_WORD1    = 2'h1;
   localparam logic [1:0]  CSR_WORD2    = 2'h2;
   localparam logic [1:0]  CSR_WORD3    = 2'h3;
   // Control word field positions
   localparam int          F_LOAD       = 0;
   localparam int          F_STORE      = 1;
   localparam int          F_FETCH      = 2;
   localparam int          F_USER       = 3;
   localparam int          F_SUPER      = 4;
   localparam int          F_MACH       = 6;
   localparam int          F_RANGE_LO   = 7;
   localparam int          F_RANGE_HI   = 10;
   localparam int          F_LINK       = 11;
   localparam int          F_RESP_LO    = 12;
   localparam int          F_RESP_HI    = 17;
   localparam int          F_TIMING     = 18;
   localparam int          F_SELECT     = 19;
   localparam int          F_WIDE_LO    = 21;
   localparam int          F_WIDE_HI    = 26;
   localparam int          F_LOCK       = 27;
   localparam int          F_KIND_LO    = 28;
   localparam int          F_KIND_HI    = 31;
   // Fixed field values
   localparam logic [3:0]  KIND_ADDR    = 4'h2;
   localparam logic [3:0]  KIND_NONE    = 4'h0;
   localparam logic [5:0]  WIDEST_LOG2  = 6'h04;
   localparam logic [5:0]  RESP_DEBUG   = 6'h01;
   localparam logic [3:0]  CAUSE_BREAK  = 4'h3;
   localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
   // Privilege levels as presented by the pipeline
   localparam logic [1:0]  PRIV_USER    = 2'h0;
   localparam logic [1:0]  PRIV_SUPER   = 2'h1;
   localparam logic [1:0]  PRIV_MACH    = 2'h3;

   // Range-kind encodings that are retained
   typedef enum logic [3:0] {
      RANGE_EXACT = 4'h0,
      RANGE_NAPOT = 4'h1,
      RANGE_GE    = 4'h2,
      RANGE_LT    = 4'h3
   } hbtu_range_type;

   // One slot's stored state
   typedef struct packed {
      logic           lock;
      logic           resp_debug;
      logic           link;
      hbtu_range_type range;
      logic           en_mach;
      logic           en_super;
      logic           en_user;
      logic           en_fetch;
      logic           en_store;
      logic           en_load;
      logic [31:0]    addr;
   } hbtu_slot_type;

   // One access presented by the pipeline
   typedef struct packed {
      logic        valid;
      logic        load;
      logic        store;
      logic        fetch;
      logic [1:0]  priv;
      logic [31:0] addr;
   } hbtu_access_type;

   // One CSR request
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [1:0]  sel;
      logic [31:0] wdata;
   } hbtu_csr_req_type;
endpackage : hbtu_pkg

// File: hdl/hbtu_trigger_unit.sv
// Purpose: Per-hart breakpoint trigger slots with CSR access and hit report
// Assumes: Pipeline and CSR file share clk_sys_i; inputs need no synchroniser
// Notes:   Compare is combinational in the access cycle; outputs registered
`timescale 1ns/100ps
`default_nettype none
module hbtu_trigger_unit
   import hbtu_pkg::*;
(
   input  wire logic             clk_sys_i,
   input  wire logic             rst_i,
   input  wire logic             debug_mode_i,
   input  wire hbtu_csr_req_type csr_req_i,
   input  wire hbtu_access_type  access_i,
   output logic                  csr_ack_o,
   output logic [31:0]           csr_rdata_o,
   output logic                  csr_illegal_o,
   output logic                  hit_exc_o,
   output logic                  hit_debug_o,
   output logic [3:0]            hit_cause_o,
   output logic [31:0]           hit_addr_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Widest range fixed at 16 bytes; extra trailing ones still clamp there
   // Mask of compared bits for a power-of-two range; clamped to 16 bytes
   function automatic logic [31:0] napot_mask(input logic [31:0] a);
      logic [31:0] m;
      m = 32'hFFFF_FFFE;
      if (a[0]) begin
         m = 32'hFFFF_FFFC;
         if (a[1]) begin
            m = 32'hFFFF_FFF8;
            if (a[2]) begin
               m = 32'hFFFF_FFF0;
            end
         end
      end
      return m;
   endfunction : napot_mask

   // Address part of a slot's condition
   function automatic logic addr_match(input hbtu_slot_type s, input logic [31:0] a);
      logic [31:0] m;
      logic        r;
      m = napot_mask(s.addr);
      unique case (s.range)
         RANGE_EXACT: r = (a == s.addr);
         RANGE_NAPOT: r = ((a & m) == (s.addr & m));
         RANGE_GE:    r = (a >= s.addr);
         RANGE_LT:    r = (a < s.addr);
         default:     r = 1'b0;
      endcase
      return r;
   endfunction : addr_match

   ////////////////////////////////////////////////////////////////////////////
   // State

   hbtu_slot_type        slot_ff [SLOTS];
   logic [IDX_W-1:0]     sel_ff;
   logic                 csr_ack_ff;
   logic [31:0]          csr_rdata_ff;
   logic                 csr_illegal_ff;
   logic                 hit_exc_ff;
   logic                 hit_debug_ff;
   logic [3:0]           hit_cause_ff;
   logic [31:0]          hit_addr_ff;

   ////////////////////////////////////////////////////////////////////////////
   // CSR decode

   hbtu_slot_type        cur_slot;
   wire logic            m_locked;
   wire logic            csr_word;
   wire logic            csr_bad;
   wire logic            wr_index;
   wire logic            wr_word1;
   wire logic            wr_word2;
   wire logic [31:0]     word1_view;
   wire logic [31:0]     rd_mux;
   wire logic [3:0]      wr_range;
   wire logic [5:0]      wr_resp;
   wire logic            range_ok;
   wire logic            resp_ok;
   logic [IDX_W-1:0]     nxt_sel;

   assign cur_slot  = slot_ff[sel_ff];
   assign m_locked  = cur_slot.lock && !debug_mode_i;
   assign csr_word  = csr_req_i.sel != CSR_INDEX;
   assign csr_bad   = csr_req_i.valid && csr_word && m_locked;
   assign wr_index  = csr_req_i.valid && csr_req_i.write && (csr_req_i.sel == CSR_INDEX);
   assign wr_word1  = csr_req_i.valid && csr_req_i.write && (csr_req_i.sel == CSR_WORD1)
                      && !m_locked;
   assign wr_word2  = csr_req_i.valid && csr_req_i.write && (csr_req_i.sel == CSR_WORD2)
                      && !m_locked;
   assign wr_range  = csr_req_i.wdata[F_RANGE_HI:F_RANGE_LO];
   assign wr_resp   = csr_req_i.wdata[F_RESP_HI:F_RESP_LO];
   assign range_ok  = wr_range <= RANGE_LT;
   assign resp_ok   = wr_resp <= RESP_DEBUG;

   // Control word view; kind, widest range, fixed zeros
   assign word1_view = {KIND_ADDR, cur_slot.lock, WIDEST_LOG2, 1'b0, 1'b0, 1'b0,
                        5'h00, cur_slot.resp_debug, cur_slot.link, cur_slot.range,
                        cur_slot.en_mach, 1'b0, cur_slot.en_super, cur_slot.en_user,
                        cur_slot.en_fetch, cur_slot.en_store, cur_slot.en_load};

   // Word selection; locked slot shows nothing to machine mode
   assign rd_mux = (csr_req_i.sel == CSR_INDEX) ? 32'(sel_ff) :
                   m_locked                     ? WORD_ZERO :
                   (csr_req_i.sel == CSR_WORD1) ? word1_view :
                   (csr_req_i.sel == CSR_WORD2) ? cur_slot.addr : WORD_ZERO;

   // Out-of-range index writes leave the index alone
   always_comb begin
      nxt_sel = sel_ff;
      if (wr_index && (csr_req_i.wdata < 32'(SLOTS))) begin
         nxt_sel = csr_req_i.wdata[IDX_W-1:0];
      end
   end

   // CSR answer registers, one cycle after the request
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         sel_ff         <= '0;
         csr_ack_ff     <= 1'b0;
         csr_rdata_ff   <= WORD_ZERO;
         csr_illegal_ff <= 1'b0;
      end else begin
         sel_ff         <= nxt_sel;
         csr_ack_ff     <= csr_req_i.valid;
         csr_rdata_ff   <= csr_req_i.valid ? rd_mux : WORD_ZERO;
         csr_illegal_ff <= csr_bad;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Slot storage

   // Reset to zero; eight slots, WARL fields keep old on bad write
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         for (int i = 0; i < SLOTS; i++) begin
            slot_ff[i] <= '0;
         end
      end else if (wr_word1) begin
         slot_ff[sel_ff].en_load  <= csr_req_i.wdata[F_LOAD];
         slot_ff[sel_ff].en_store <= csr_req_i.wdata[F_STORE];
         slot_ff[sel_ff].en_fetch <= csr_req_i.wdata[F_FETCH];
         slot_ff[sel_ff].en_user  <= csr_req_i.wdata[F_USER];
         slot_ff[sel_ff].en_super <= csr_req_i.wdata[F_SUPER];
         slot_ff[sel_ff].en_mach  <= csr_req_i.wdata[F_MACH];
         if (range_ok) begin
            slot_ff[sel_ff].range <= hbtu_range_type'(wr_range);
         end
         if (resp_ok) begin
            slot_ff[sel_ff].resp_debug <= wr_resp[0];
         end
         // Last slot has no partner, so its link bit stays clear
         slot_ff[sel_ff].link <= csr_req_i.wdata[F_LINK] && (sel_ff != IDX_W'(SLOTS-1));
         // Only debug mode may claim or release a slot
         if (debug_mode_i) begin
            slot_ff[sel_ff].lock <= csr_req_i.wdata[F_LOCK];
         end
      end else if (wr_word2) begin
         slot_ff[sel_ff].addr <= csr_req_i.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Match logic

   logic [SLOTS-1:0]     cond;
   logic [SLOTS-1:0]     fire;
   logic [IDX_W-1:0]     win_idx;
   logic                 any_fire;

   // Same-cycle qualified compare; no triggers while in debug mode
   always_comb begin
      for (int i = 0; i < SLOTS; i++) begin
         cond[i] = access_i.valid && !debug_mode_i
                   && ((access_i.load  && slot_ff[i].en_load)
                    || (access_i.store && slot_ff[i].en_store)
                    || (access_i.fetch && slot_ff[i].en_fetch))
                   && ((access_i.priv == PRIV_USER  && slot_ff[i].en_user)
                    || (access_i.priv == PRIV_SUPER && slot_ff[i].en_super)
                    || (access_i.priv == PRIV_MACH  && slot_ff[i].en_mach))
                   && addr_match(slot_ff[i], access_i.addr);
      end
   end

   // Chained pairs; lower slot low bound, upper slot end bound
   // Slot zero has no lower partner, so it stands outside the loop
   always_comb begin
      fire[0] = cond[0] && !slot_ff[0].link;
      for (int i = 1; i < SLOTS; i++) begin
         fire[i] = cond[i] && !slot_ff[i].link && !(slot_ff[i-1].link && !cond[i-1]);
      end
   end

   // Lowest-numbered firing slot decides the response
   always_comb begin
      win_idx  = '0;
      any_fire = 1'b0;
      for (int i = SLOTS - 1; i >= 0; i--) begin
         if (fire[i]) begin
            win_idx  = IDX_W'(i);
            any_fire = 1'b1;
         end
      end
   end

   // Precise hit report with faulting address; response choice
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         hit_exc_ff   <= 1'b0;
         hit_debug_ff <= 1'b0;
         hit_cause_ff <= CAUSE_BREAK;
         hit_addr_ff  <= WORD_ZERO;
      end else begin
         // Cause is fixed; held in a flop so every output leaves a register
         hit_cause_ff <= CAUSE_BREAK;
         hit_exc_ff   <= any_fire && !slot_ff[win_idx].resp_debug;
         hit_debug_ff <= any_fire && slot_ff[win_idx].resp_debug;
         hit_addr_ff  <= any_fire ? access_i.addr : hit_addr_ff;
      end
   end

   assign csr_ack_o     = csr_ack_ff;
   assign csr_rdata_o   = csr_rdata_ff;
   assign csr_illegal_o = csr_illegal_ff;
   assign hit_exc_o     = hit_exc_ff;
   assign hit_debug_o   = hit_debug_ff;
   assign hit_cause_o   = hit_cause_ff;
   assign hit_addr_o    = hit_addr_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   wire logic rd_word1 = csr_req_i.valid && !csr_req_i.write
                         && (csr_req_i.sel == CSR_WORD1) && !m_locked;

   sequence seq_locked_access;
      csr_req_i.valid && csr_word && cur_slot.lock && !debug_mode_i;
   endsequence

   sequence seq_plain_fire;
      any_fire && !slot_ff[win_idx].resp_debug;
   endsequence

   sequence seq_debug_fire;
      any_fire && slot_ff[win_idx].resp_debug;
   endsequence

   wire logic bad_index = wr_index && (csr_req_i.wdata >= 32'(SLOTS));

   kind_field_a: assert property (rd_word1 |=>
      csr_rdata_o[F_KIND_HI:F_KIND_LO] == KIND_ADDR)
      else $error("kind field not 2");
   widest_range_a: assert property (rd_word1 |=>
      csr_rdata_o[F_WIDE_HI:F_WIDE_LO] == WIDEST_LOG2)
      else $error("widest range field not 4");
   fixed_zero_a: assert property (rd_word1 |=>
      !csr_rdata_o[F_TIMING] && !csr_rdata_o[F_SELECT])
      else $error("timing or select bit set");
   lock_illegal_a: assert property (seq_locked_access |=>
      csr_illegal_o && csr_ack_o && csr_rdata_o == WORD_ZERO)
      else $error("locked slot access not refused");
   resp_legal_a: assert property (wr_word1 && !resp_ok |=>
      slot_ff[$past(sel_ff)].resp_debug == $past(cur_slot.resp_debug))
      else $error("illegal response value retained");
   range_legal_a: assert property (wr_word1 && !range_ok |=>
      slot_ff[$past(sel_ff)].range == $past(cur_slot.range))
      else $error("illegal range kind retained");
   chain_block_a: assert property (slot_ff[0].link && !cond[0] |-> !fire[1])
      else $error("chained slot fired alone");
   exc_route_a: assert property (seq_plain_fire |=>
      hit_exc_o && !hit_debug_o && hit_addr_o == $past(access_i.addr))
      else $error("exception hit not reported");
   no_access_a: assert property (!access_i.valid |=> !hit_exc_o && !hit_debug_o)
      else $error("hit without access");
   debug_route_a: assert property (seq_debug_fire |=>
      hit_debug_o && !hit_exc_o && hit_addr_o == $past(access_i.addr))
      else $error("debug hit not reported");
   debug_quiet_a: assert property (debug_mode_i |=> !hit_exc_o && !hit_debug_o)
      else $error("hit while in debug mode");
   csr_ack_a: assert property (csr_req_i.valid |=> csr_ack_o)
      else $error("request not acknowledged");
   index_keep_a: assert property (bad_index |=> sel_ff == $past(sel_ff))
      else $error("out of range index taken");
   lock_write_a: assert property (wr_word1 && !debug_mode_i |=>
      slot_ff[$past(sel_ff)].lock == $past(cur_slot.lock))
      else $error("lock changed outside debug mode");
   last_link_a: assert property (!slot_ff[SLOTS-1].link)
      else $error("last slot link set");
endmodule : hbtu_trigger_unit
`default_nettype wire

// File: dv/hbtu_pipe_model.sv
// Purpose: Pipeline stand-in that presents one access per request
// Assumes: Request sampled on the rising edge of clk_sys_i
// Notes:   Idle cycles flip the address so a stale value never looks live
`timescale 1ns/100ps
`default_nettype none
module hbtu_pipe_model
   import hbtu_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        go_i,
   input  wire logic [2:0]  kind_i,
   input  wire logic [1:0]  priv_i,
   input  wire logic [31:0] addr_i,
   output hbtu_access_type  access_o
);
   ////////////////////////////////////////////////////////////////////////
   // One registered access per go cycle; between accesses nothing holds
   always_ff @(posedge clk_sys_i) begin
      access_o.valid <= go_i;
      access_o.load  <= go_i & kind_i[0];
      access_o.store <= go_i & kind_i[1];
      access_o.fetch <= go_i & kind_i[2];
      access_o.priv  <= go_i ? priv_i : ~priv_i;
      access_o.addr  <= go_i ? addr_i : ~access_o.addr;
   end
endmodule : hbtu_pipe_model
`default_nettype wire

// File: dv/hbtu_trigger_unit_bench.sv
// Purpose: Self-checking bench for the breakpoint trigger unit
// Assumes: CSR answers come one cycle after the request edge, hit reports two cycles after it
// Notes:   Table rows cover single-slot matches; chain and lock by hand
`timescale 1ns/100ps
`default_nettype none
module hbtu_trigger_unit_bench
   import hbtu_pkg::*;
;
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] maddr;
      logic [2:0]  kind;
      logic [1:0]  priv;
      logic [31:0] addr;
      logic        exc;
      logic        dbg;
   } hbtu_row_type;
   localparam hbtu_row_type ROWS [11] = '{
      '{32'h0000_0041, 32'h0000_1000, 3'h1, PRIV_MACH, 32'h0000_1000, 1'b1, 1'b0},
      '{32'h0000_0041, 32'h0000_1000, 3'h1, PRIV_MACH, 32'h0000_1001, 1'b0, 1'b0},
      '{32'h0000_0041, 32'h0000_1000, 3'h2, PRIV_MACH, 32'h0000_1000, 1'b0, 1'b0},
      '{32'h0000_0041, 32'h0000_1000, 3'h1, PRIV_USER, 32'h0000_1000, 1'b0, 1'b0},
      '{32'h0000_00C1, 32'h0000_1000, 3'h1, PRIV_MACH, 32'h0000_1001, 1'b1, 1'b0},
      '{32'h0000_00C1, 32'h0000_1001, 3'h1, PRIV_MACH, 32'h0000_1003, 1'b1, 1'b0},
      '{32'h0000_00C1, 32'h0000_1001, 3'h1, PRIV_MACH, 32'h0000_1004, 1'b0, 1'b0},
      '{32'h0000_00C1, 32'h0000_10FF, 3'h1, PRIV_MACH, 32'h0000_10F5, 1'b1, 1'b0},
      '{32'h0000_00C1, 32'h0000_10FF, 3'h1, PRIV_MACH, 32'h0000_10E5, 1'b0, 1'b0},
      '{32'h0000_1014, 32'h0000_2000, 3'h4, PRIV_SUPER, 32'h0000_2000, 1'b0, 1'b1},
      '{32'h0000_000A, 32'h0000_2000, 3'h2, PRIV_USER, 32'h0000_2000, 1'b1, 1'b0}};
   localparam logic [31:0] CTRL_RST = 32'h2080_0000;
   logic             clk_sys_i;
   logic             rst_i;
   logic             debug_mode_i;
   logic             go;
   logic [2:0]       kind;
   logic [1:0]       priv;
   logic [31:0]      addr;
   hbtu_csr_req_type csr_req;
   hbtu_access_type  access;
   logic             csr_ack;
   logic             csr_ill;
   logic             hit_exc;
   logic             hit_dbg;
   logic [3:0]       hit_cause;
   logic [31:0]      csr_rdata;
   logic [31:0]      hit_addr;
   int               fail_count;
   int               n_tests;

   ////////////////////////////////////////////////////////////////////////
   // Design and pipeline stand-in
   hbtu_trigger_unit dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .debug_mode_i(debug_mode_i),
      .csr_req_i(csr_req), .access_i(access), .csr_ack_o(csr_ack), .csr_rdata_o(csr_rdata),
      .csr_illegal_o(csr_ill), .hit_exc_o(hit_exc), .hit_debug_o(hit_dbg),
      .hit_cause_o(hit_cause), .hit_addr_o(hit_addr));
   hbtu_pipe_model pipe (.clk_sys_i(clk_sys_i), .go_i(go), .kind_i(kind), .priv_i(priv),
      .addr_i(addr), .access_o(access));

   ////////////////////////////////////////////////////////////////////////
   // Comparison, bus and access tasks
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, got, exp);
      end
   endtask : chk
   task csr(input logic w, input logic [1:0] s, input logic [31:0] d, input logic ill);
      @(posedge clk_sys_i);
      csr_req <= '{valid: 1'b1, write: w, sel: s, wdata: d};
      @(posedge clk_sys_i);
      csr_req.valid <= 1'b0;
      #1;
      chk({31'h0, csr_ack}, 32'h1);
      chk({31'h0, csr_ill}, {31'h0, ill});
      if (!w) chk(csr_rdata, d);
   endtask : csr
   task acc(input logic [2:0] k, input logic [1:0] p, input logic [31:0] a, input logic e,
            input logic g);
      @(posedge clk_sys_i);
      go <= 1'b1;
      kind <= k;
      priv <= p;
      addr <= a;
      @(posedge clk_sys_i);
      go <= 1'b0;
      @(posedge clk_sys_i);
      #1;
      chk({30'h0, hit_exc, hit_dbg}, {30'h0, e, g});
      if (e | g) chk(hit_addr, a);
      chk({28'h0, hit_cause}, {28'h0, CAUSE_BREAK});
   endtask : acc
   task reset;
      @(posedge clk_sys_i);
      rst_i <= 1'b1;
      repeat (16) @(posedge clk_sys_i);
      rst_i <= 1'b0;
   endtask : reset
   task test_done;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done

   ////////////////////////////////////////////////////////////////////////
   // Clock and watchdog; no run may hang past the bound
   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      fail_count++;
      test_done();
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst_i = 1'b1;
      debug_mode_i = 1'b0;
      go = 1'b0;
      kind = 3'h0;
      priv = 2'h0;
      addr = 32'h0;
      csr_req = '0;
      fail_count = 0;
      n_tests = 0;
      reset();
      // Outputs idle and index clear straight after reset
      #1;
      chk({29'h0, csr_ack, hit_exc, hit_dbg}, 32'h0);
      chk(csr_rdata, 32'h0);
      chk(hit_addr, 32'h0);
      csr(1'b0, CSR_INDEX, 32'h0, 1'b0);
      $display("first reset test done");
      // Table of single-slot matches on slot zero
      csr(1'b1, CSR_INDEX, 32'h0, 1'b0);
      foreach (ROWS[i]) begin
         csr(1'b1, CSR_WORD1, ROWS[i].ctrl, 1'b0);
         csr(1'b1, CSR_WORD2, ROWS[i].maddr, 1'b0);
         csr(1'b0, CSR_WORD2, ROWS[i].maddr, 1'b0);
         acc(ROWS[i].kind, ROWS[i].priv, ROWS[i].addr, ROWS[i].exc, ROWS[i].dbg);
      end
      $display("match table done");
      // Paired range, low bound inclusive, top exclusive
      csr(1'b1, CSR_WORD1, 32'h0000_0941, 1'b0);
      csr(1'b1, CSR_WORD2, 32'h0000_3000, 1'b0);
      csr(1'b1, CSR_INDEX, 32'h1, 1'b0);
      csr(1'b1, CSR_WORD1, 32'h0000_01C1, 1'b0);
      csr(1'b1, CSR_WORD2, 32'h0000_3010, 1'b0);
      acc(3'h1, PRIV_MACH, 32'h0000_3000, 1'b1, 1'b0);
      acc(3'h1, PRIV_MACH, 32'h0000_300F, 1'b1, 1'b0);
      acc(3'h1, PRIV_MACH, 32'h0000_3010, 1'b0, 1'b0);
      acc(3'h1, PRIV_MACH, 32'h0000_2FFF, 1'b0, 1'b0);
      $display("chain tests done");
      // Illegal field values leave the field alone; range stays at code 2
      csr(1'b1, CSR_INDEX, 32'h0, 1'b0);
      csr(1'b1, CSR_WORD1, 32'hFFFF_FFFF, 1'b0);
      csr(1'b0, CSR_WORD1, 32'h2080_095F, 1'b0);
      csr(1'b1, CSR_WORD1, 32'h0000_1100, 1'b0);
      csr(1'b1, CSR_WORD1, 32'h0000_2780, 1'b0);
      csr(1'b0, CSR_WORD1, 32'h2080_1100, 1'b0);
      csr(1'b1, CSR_INDEX, 32'h7, 1'b0);
      csr(1'b1, CSR_WORD1, 32'h0800_0800, 1'b0);
      csr(1'b0, CSR_WORD1, CTRL_RST, 1'b0);
      $display("field legality tests done");
      // Debug-locked slot hidden from machine mode
      @(posedge clk_sys_i) debug_mode_i <= 1'b1;
      csr(1'b1, CSR_INDEX, 32'h2, 1'b0);
      csr(1'b1, CSR_WORD1, 32'h0800_0041, 1'b0);
      csr(1'b0, CSR_WORD1, 32'h2880_0041, 1'b0);
      acc(3'h1, PRIV_MACH, 32'h0000_0000, 1'b0, 1'b0);
      @(posedge clk_sys_i) debug_mode_i <= 1'b0;
      csr(1'b0, CSR_WORD1, 32'h0, 1'b1);
      csr(1'b1, CSR_WORD2, 32'h0000_5555, 1'b1);
      @(posedge clk_sys_i) debug_mode_i <= 1'b1;
      csr(1'b0, CSR_WORD2, 32'h0, 1'b0);
      @(posedge clk_sys_i) debug_mode_i <= 1'b0;
      $display("lock tests done");
      // Second reset in mid-run clears every slot, lock included
      reset();
      csr(1'b0, CSR_INDEX, 32'h0, 1'b0);
      for (int i = 0; i < SLOTS; i++) begin
         csr(1'b1, CSR_INDEX, i, 1'b0);
         csr(1'b0, CSR_WORD1, CTRL_RST, 1'b0);
         csr(1'b0, CSR_WORD2, 32'h0, 1'b0);
      end
      csr(1'b1, CSR_INDEX, 32'h8, 1'b0);
      csr(1'b0, CSR_INDEX, 32'h7, 1'b0);
      csr(1'b1, CSR_WORD3, 32'hFFFF_FFFF, 1'b0);
      csr(1'b0, CSR_WORD3, 32'h0, 1'b0);
      $display("second reset and select tests done");
      test_done();
   end
endmodule : hbtu_trigger_unit_bench
`default_nettype wire
